// ===== logic/ldc_disconnected_ctrl.sv
`timescale 1ns/1ps
// How it works
// - enter on stop with tx on, or disconnect done
// - rx select 11b behaves as PHY off
// - low power 1-3 disables lanes; 2-3 clock too
// - keep DLL lock unless deep state or retune
// - divided state divides clock; PLL relocks on retune
// - reset goes to warm reset first
// - narrowed lanes go inactive; tx off to PHY off
// - clock back at programmed rate within 900ns
// - tx to training 0, full or short time
// - rx waits 1000ns before tracking, then training
// - slow clock return needs select bit 1 zero
// - DLL relocks after frequency change
// - clock switch glitch free, never above link rate
// - state zero or one: DLL lock held, scrambled or not
// - phase recovery keeps seeking until lock
// - inactive lane timer ignores lanes above width under width lock
// - scramble inactive lanes until retrained
module ldc_disconnected_ctrl
   import ldc_pkg::*;
#(
   parameter int LANES = 16,
   parameter int TW = TIMER_W
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic link_stop_n_i,
   input wire logic link_reset_n_i,
   input wire logic transmitter_off_i,
   input wire logic disconnect_done_i,
   input wire logic [1:0] rx_low_power_select_i,
   input wire logic [1:0] tx_low_power_select_i,
   input wire logic [1:0] inactive_lane_state_i,
   input wire logic freq_change_i,
   input wire logic pll_locked_i,
   input wire logic tx_ready_i,
   input wire logic rx_ready_i,
   input wire logic dll_locked_i,
   input wire logic phase_locked_i,
   input wire logic [LANES-1:0] active_lanes_i,
   input wire logic lane_width_lock_i,
   input wire logic [TW-1:0] idle_limit_i,
   input wire logic [TW-1:0] inactive_limit_i,
   output logic [2:0] link_state_o,
   output logic rx_phy_off_o,
   output logic rx_termination_o,
   output logic rx_lane_input_en_o,
   output logic rx_clock_input_en_o,
   output logic dll_hold_lock_o,
   output logic dll_relock_o,
   output logic pll_relock_o,
   output logic clock_divided_o,
   output logic clock_return_late_o,
   output logic rx_track_en_o,
   output logic full_train0_o,
   output logic train0_start_o,
   output logic [LANES-1:0] lanes_inactive_o,
   output logic [LANES-1:0] lanes_scramble_o,
   output logic inactive_timeout_o
);
   ldc_state_type state_ff, nxt_state;
   logic [SYNC_STAGES-1:0] stop_sync_ff, rst_sync_ff;
   logic stop_n, link_rst_n;
   logic stop_n_prev_ff;
   logic [TW-1:0] idle_cnt_ff, inact_cnt_ff;
   logic idle_over_ff;
   logic [5:0] wake_cnt_ff;
   logic waking_ff;
   logic freq_pending_ff;
   logic clk_div_ff, rx_lanes_en_ff, rx_clk_en_ff, dll_hold_ff;
   logic late_ff, track_ff, full_ff, start_ff;
   logic [LANES-1:0] inact_ff, scr_ff;
   logic inact_to_ff;
   logic deep;

   // synchroniser: only the last stage is read
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         stop_sync_ff <= '1;
         rst_sync_ff <= '1;
      end else begin
         stop_sync_ff <= {stop_sync_ff[SYNC_STAGES-2:0], link_stop_n_i};
         rst_sync_ff <= {rst_sync_ff[SYNC_STAGES-2:0], link_reset_n_i};
      end
   end
   assign stop_n = stop_sync_ff[SYNC_STAGES-1];
   assign link_rst_n = rst_sync_ff[SYNC_STAGES-1];

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) stop_n_prev_ff <= 1'b1;
      else stop_n_prev_ff <= stop_n;
   end

   assign deep = (tx_low_power_select_i == LP_STATE_TWO) ||
                 (tx_low_power_select_i == LP_STATE_THREE);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         LDC_OPERATIONAL: begin
            if (!link_rst_n) nxt_state = LDC_WARM_RESET;
            else if ((!stop_n && !transmitter_off_i) || disconnect_done_i)
               nxt_state = LDC_DISCONNECTED;
         end
         LDC_DISCONNECTED: begin
            if (!link_rst_n) nxt_state = LDC_WARM_RESET;
            else if (transmitter_off_i) nxt_state = LDC_PHY_OFF;
            else if (waking_ff && tx_ready_i && !pll_relock_o)
               nxt_state = LDC_TRAIN0;
         end
         LDC_WARM_RESET: begin
            if (link_rst_n) nxt_state = LDC_TRAIN0;
         end
         LDC_PHY_OFF: begin
            if (!link_rst_n) nxt_state = LDC_WARM_RESET;
            else if (!transmitter_off_i) nxt_state = LDC_TRAIN0;
         end
         LDC_TRAIN0: begin
            if (!link_rst_n) nxt_state = LDC_WARM_RESET;
            else if (rx_ready_i && dll_locked_i && phase_locked_i &&
                     track_ff)
               nxt_state = LDC_OPERATIONAL;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) state_ff <= LDC_WARM_RESET;
      else state_ff <= nxt_state;
   end

   // wake-up window after stop release; counts to the longer of the waits
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         waking_ff <= 1'b0;
         wake_cnt_ff <= '0;
      end else if (!(state_ff == LDC_DISCONNECTED ||
                     state_ff == LDC_TRAIN0) || !stop_n) begin
         waking_ff <= 1'b0;
         wake_cnt_ff <= '0;
      end else if (!stop_n_prev_ff) begin
         waking_ff <= 1'b1;
         wake_cnt_ff <= '0;
      end else if (wake_cnt_ff != 6'(RX_WAIT_CYC)) begin
         wake_cnt_ff <= wake_cnt_ff + 6'h01;
      end
   end

   // receiver starts tracking only after the wait, even if tx trains early
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) track_ff <= 1'b1;
      else if (state_ff == LDC_DISCONNECTED ||
               (state_ff == LDC_TRAIN0 && waking_ff))
         track_ff <= waking_ff && wake_cnt_ff == 6'(RX_WAIT_CYC);
      else track_ff <= 1'b1;
   end

   // clock must be back by the deadline; flag a late return
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) late_ff <= 1'b0;
      else if (waking_ff && wake_cnt_ff == 6'(CLK_RETURN_CYC) &&
               (clk_div_ff || !pll_locked_i))
         late_ff <= 1'b1;
      else if (state_ff == LDC_OPERATIONAL)
         late_ff <= 1'b0;
   end

   // divided clock only while stop held; switch registered so no glitch
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) clk_div_ff <= 1'b0;
      else clk_div_ff <= state_ff == LDC_DISCONNECTED && !stop_n &&
                         tx_low_power_select_i == LP_STATE_ONE;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) freq_pending_ff <= 1'b0;
      else if (state_ff == LDC_DISCONNECTED && freq_change_i)
         freq_pending_ff <= 1'b1;
      else if (state_ff == LDC_DISCONNECTED && pll_locked_i && stop_n)
         freq_pending_ff <= 1'b0;
   end

   // receiver lane and clock input gating
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         rx_lanes_en_ff <= 1'b1;
         rx_clk_en_ff <= 1'b1;
      end else if (state_ff == LDC_DISCONNECTED && !stop_n) begin
         rx_lanes_en_ff <= rx_low_power_select_i == LP_STATE_ZERO;
         rx_clk_en_ff <= !rx_low_power_select_i[LP_CLOCK_BIT];
      end else begin
         rx_lanes_en_ff <= 1'b1;
         rx_clk_en_ff <= 1'b1;
      end
   end

   // DLL lock held while disconnected in states zero and one; released for deep states or retune
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) dll_hold_ff <= 1'b0;
      else dll_hold_ff <= state_ff == LDC_DISCONNECTED && !deep &&
                          !freq_pending_ff && !freq_change_i;
   end

   // idle timer picks full or short training time
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         idle_cnt_ff <= '0;
         idle_over_ff <= 1'b0;
      end else if (state_ff == LDC_DISCONNECTED) begin
         if (idle_cnt_ff != '1) idle_cnt_ff <= idle_cnt_ff + 1'b1;
         if (idle_cnt_ff > idle_limit_i) idle_over_ff <= 1'b1;
      end else if (state_ff == LDC_OPERATIONAL) begin
         idle_cnt_ff <= '0;
         idle_over_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         full_ff <= 1'b1;
         start_ff <= 1'b0;
      end else begin
         start_ff <= nxt_state == LDC_TRAIN0 && state_ff != LDC_TRAIN0;
         if (nxt_state == LDC_TRAIN0 && state_ff == LDC_DISCONNECTED)
            full_ff <= idle_over_ff;
         else if (nxt_state == LDC_TRAIN0 && state_ff != LDC_TRAIN0)
            full_ff <= 1'b1;
      end
   end

   // lanes above the width go inactive; scrambled if so configured
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         inact_ff <= '0;
         scr_ff <= '0;
      end else begin
         if (state_ff == LDC_DISCONNECTED) inact_ff <= ~active_lanes_i;
         if (state_ff == LDC_OPERATIONAL &&
             (inactive_lane_state_i == INLANE_SCRAMBLE ||
              (inactive_lane_state_i == INLANE_ALT &&
               tx_low_power_select_i == LP_STATE_ONE)))
            scr_ff <= inact_ff;
         else if (state_ff == LDC_WARM_RESET ||
                  (state_ff == LDC_DISCONNECTED && !stop_n))
            scr_ff <= '0;
      end
   end

   // timer on inactive lanes; under width lock the upper lanes never count
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         inact_cnt_ff <= '0;
         inact_to_ff <= 1'b0;
      end else if (!lane_width_lock_i && |inact_ff) begin
         if (inact_cnt_ff != '1) inact_cnt_ff <= inact_cnt_ff + 1'b1;
         inact_to_ff <= inact_cnt_ff > inactive_limit_i;
      end else begin
         inact_cnt_ff <= '0;
         inact_to_ff <= 1'b0;
      end
   end

   assign link_state_o = state_ff;
   assign rx_phy_off_o = state_ff == LDC_PHY_OFF ||
      (state_ff == LDC_DISCONNECTED &&
       rx_low_power_select_i == LP_STATE_THREE);
   assign rx_termination_o = !rx_phy_off_o;
   assign rx_lane_input_en_o = rx_lanes_en_ff;
   assign rx_clock_input_en_o = rx_clk_en_ff;
   assign dll_hold_lock_o = dll_hold_ff;
   assign dll_relock_o = freq_pending_ff;
   assign pll_relock_o = freq_pending_ff;
   assign clock_divided_o = clk_div_ff;
   assign clock_return_late_o = late_ff;
   assign rx_track_en_o = track_ff;
   assign full_train0_o = full_ff;
   assign train0_start_o = start_ff;
   assign lanes_inactive_o = inact_ff;
   assign lanes_scramble_o = scr_ff;
   assign inactive_timeout_o = inact_to_ff;
endmodule : ldc_disconnected_ctrl

// ===== logic/ldc_pkg.sv
package ldc_pkg;
   // link training state machine positions this block cares about
   typedef enum logic [2:0] {
      LDC_OPERATIONAL,
      LDC_DISCONNECTED,
      LDC_WARM_RESET,
      LDC_PHY_OFF,
      LDC_TRAIN0
   } ldc_state_type;

   // low-power select encodings
   localparam logic [1:0] LP_STATE_ZERO = 2'h0;
   localparam logic [1:0] LP_STATE_ONE = 2'h1;
   localparam logic [1:0] LP_STATE_TWO = 2'h2;
   localparam logic [1:0] LP_STATE_THREE = 2'h3;
   localparam int LP_CLOCK_BIT = 1;

   // inactive lane state encodings
   localparam logic [1:0] INLANE_SCRAMBLE = 2'h2;
   localparam logic [1:0] INLANE_ALT = 2'h3;

   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int CLK_RETURN_NS = 900;
   localparam int RX_WAIT_NS = 1000;
   // longest time rounds down, least time rounds up
   localparam int CLK_RETURN_CYC = CLK_RETURN_NS / CLK_PERIOD_NS;
   localparam int RX_WAIT_CYC = (RX_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   localparam int TIMER_W = 24;
endpackage : ldc_pkg

// ===== tb/ldc_disconnected_ctrl_checker.sv
`timescale 1ns/1ps
module ldc_checker
   import ldc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic link_stop_n_i,
   input wire logic link_reset_n_i,
   input wire logic transmitter_off_i,
   input wire logic [1:0] rx_low_power_select_i,
   input wire logic [2:0] link_state_o,
   input wire logic rx_phy_off_o,
   input wire logic rx_termination_o,
   input wire logic rx_clock_input_en_o,
   input wire logic dll_relock_o,
   input wire logic pll_relock_o,
   input wire logic rx_track_en_o,
   input wire logic train0_start_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   int hi_cnt;
   logic disc;
   assign disc = link_state_o == LDC_DISCONNECTED;
   // saturates so a long idle cannot wrap
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || !link_stop_n_i) begin
         hi_cnt <= 0;
      end else if (hi_cnt < 1000) begin
         hi_cnt <= hi_cnt + 1;
      end
   end
   sequence s_rst_low; (!link_reset_n_i) [*3]; endsequence
   sequence s_rst_high; link_reset_n_i [*3]; endsequence
   sequence s_stop_low; (!link_stop_n_i) [*4]; endsequence
   a_rst_entry_warm: assert property ($rose(rst_b_i) |->
      link_state_o == LDC_WARM_RESET) else $error("no warm reset");
   a_reset_wins: assert property (s_rst_low ##0 disc |-> ##[1:2]
      link_state_o == LDC_WARM_RESET) else $error("reset ignored");
   a_transmitter_off_phy: assert property (s_rst_high ##0
      (transmitter_off_i && disc) |-> ##[1:2] link_state_o == LDC_PHY_OFF)
      else $error("tx off ignored");
   a_rx_phy_off: assert property (disc && rx_low_power_select_i == 2'h3
      |-> rx_phy_off_o) else $error("rx not off");
   a_term_kept: assert property (disc && rx_low_power_select_i != 2'h3
      |-> rx_termination_o) else $error("termination lost");
   a_clock_in_off: assert property (s_stop_low ##0 (disc && $past(disc)
      && rx_low_power_select_i[1] && $stable(rx_low_power_select_i))
      |-> !rx_clock_input_en_o) else $error("clock input on");
   a_relock_pair: assert property (dll_relock_o == pll_relock_o)
      else $error("relock split");
   a_train_pulse: assert property (train0_start_o |=> !train0_start_o)
      else $error("start pulse long");
   a_track_wait: assert property ($rose(rx_track_en_o) && (disc ||
      link_state_o == LDC_TRAIN0) |-> hi_cnt >= RX_WAIT_CYC)
      else $error("tracking early");
endmodule : ldc_checker
bind ldc_disconnected_ctrl ldc_checker u_chk (.clock_i, .rst_b_i,
   .link_stop_n_i, .link_reset_n_i, .transmitter_off_i,
   .rx_low_power_select_i, .link_state_o, .rx_phy_off_o, .rx_termination_o,
   .rx_clock_input_en_o, .dll_relock_o, .pll_relock_o, .rx_track_en_o,
   .train0_start_o);

// ===== tb/ldc_peer_model.sv
`timescale 1ns/1ps
module ldc_peer_model
   import ldc_pkg::*;
(
   input wire logic clock_i,
   input wire logic [2:0] link_state_i,
   input wire logic relock_i,
   input wire logic slow_i,
   output logic pll_locked_o,
   output logic dll_locked_o,
   output logic phase_locked_o,
   output logic tx_ready_o,
   output logic rx_ready_o
);
   int cnt;
   int lat;
   logic [2:0] prev = 3'h0;
   always @(posedge clock_i) begin
      prev <= link_state_i;
      cnt <= (link_state_i != prev) ? 0 : cnt + 1;
   end
   // slow peer outlasts the clock return window
   assign lat = slow_i ? 60 : 4;
   assign pll_locked_o = !relock_i || cnt > lat;
   assign tx_ready_o = pll_locked_o && cnt > lat;
   assign dll_locked_o = link_state_i == LDC_TRAIN0 && cnt > lat;
   assign phase_locked_o = dll_locked_o;
   assign rx_ready_o = dll_locked_o;
endmodule : ldc_peer_model

// ===== tb/tb_ldc_disconnected_ctrl.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
   end end
module tb_ldc_disconnected_ctrl
   import ldc_pkg::*;
;
   logic clk, rst_b, stop_n, lrst_n, tx_off, freq, slow, pll, dll, ph, txr, rxr;
   logic [1:0] sel, in_st;
   logic [15:0] lanes, inact, scr;
   logic [23:0] lim;
   logic [2:0] st;
   logic phy_off, term, lane_en, clk_en, relock, divd, late, track, full;
   logic hold, tmo, wlock;
   int n_mismatch = 0;
   int samples_checked = 0;
   ldc_disconnected_ctrl DUT (.clock_i(clk), .rst_b_i(rst_b),
      .link_stop_n_i(stop_n), .link_reset_n_i(lrst_n),
      .transmitter_off_i(tx_off), .disconnect_done_i(1'b0),
      .rx_low_power_select_i(sel), .tx_low_power_select_i(sel),
      .inactive_lane_state_i(in_st), .freq_change_i(freq),
      .pll_locked_i(pll), .tx_ready_i(txr), .rx_ready_i(rxr),
      .dll_locked_i(dll), .phase_locked_i(ph), .active_lanes_i(lanes),
      .lane_width_lock_i(wlock), .idle_limit_i(lim),
      .inactive_limit_i(24'h000100), .link_state_o(st),
      .rx_phy_off_o(phy_off), .rx_termination_o(term),
      .rx_lane_input_en_o(lane_en), .rx_clock_input_en_o(clk_en),
      .dll_hold_lock_o(hold), .dll_relock_o(relock), .pll_relock_o(),
      .clock_divided_o(divd), .clock_return_late_o(late),
      .rx_track_en_o(track), .full_train0_o(full), .train0_start_o(),
      .lanes_inactive_o(inact), .lanes_scramble_o(scr),
      .inactive_timeout_o(tmo));
   ldc_peer_model u_peer (.clock_i(clk), .link_state_i(st),
      .relock_i(relock), .slow_i(slow), .pll_locked_o(pll),
      .dll_locked_o(dll), .phase_locked_o(ph), .tx_ready_o(txr),
      .rx_ready_o(rxr));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   task go(input logic [2:0] s);
      for (int i = 0; i < 400 && st !== s; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK(st, s)
   endtask : go
   task do_reset;
      @(posedge clk);
      rst_b <= 0;
      lrst_n <= 0;
      tx_off <= 0;
      stop_n <= 1;
      repeat (4) @(posedge clk);
      #1;
      `CHK(st, LDC_WARM_RESET)
      `CHK({full, track}, 2'h3)
      @(posedge clk);
      rst_b <= 1;
      lrst_n <= 1;
      go(LDC_OPERATIONAL);
   endtask : do_reset
   task t_sleep(input logic [1:0] s);
      int n;
      @(posedge clk);
      sel <= s;
      stop_n <= 0;
      go(LDC_DISCONNECTED);
      repeat (3) @(posedge clk);
      #1;
      `CHK(phy_off, s == 2'h3)
      `CHK(lane_en, s == LP_STATE_ZERO)
      `CHK(clk_en, !s[LP_CLOCK_BIT])
      `CHK(divd, s == LP_STATE_ONE)
      `CHK(hold, !s[1])
      @(posedge clk);
      stop_n <= 1;
      for (n = 0; !track && n < 200; n++) begin
         @(posedge clk);
         #1;
      end
      if (s != 2'h0) `CHK(n >= RX_WAIT_CYC, 1'b1)
      go(LDC_TRAIN0);
      `CHK(full, 1'b0)
      go(LDC_OPERATIONAL);
   endtask : t_sleep
   task t_idle;
      @(posedge clk);
      lim <= 24'h000010;
      stop_n <= 0;
      go(LDC_DISCONNECTED);
      repeat (40) @(posedge clk);
      stop_n <= 1;
      go(LDC_TRAIN0);
      `CHK(full, 1'b1)
      go(LDC_OPERATIONAL);
      lim <= 24'h00ffff;
   endtask : t_idle
   task t_retune;
      @(posedge clk);
      freq <= 1;
      slow <= 1;
      stop_n <= 0;
      go(LDC_DISCONNECTED);
      repeat (3) @(posedge clk);
      #1;
      `CHK(relock, 1'b1)
      `CHK(hold, 1'b0)
      @(posedge clk);
      stop_n <= 1;
      freq <= 0;
      repeat (30) @(posedge clk);
      #1;
      `CHK(late, 1'b1)
      go(LDC_TRAIN0);
      go(LDC_OPERATIONAL);
      slow <= 0;
   endtask : t_retune
   task t_warm;
      @(posedge clk);
      stop_n <= 0;
      go(LDC_DISCONNECTED);
      @(posedge clk);
      lrst_n <= 0;
      repeat (2) @(posedge clk);
      tx_off <= 1;
      @(posedge clk);
      #1;
      `CHK(st, LDC_WARM_RESET)
      @(posedge clk);
      lrst_n <= 1;
      tx_off <= 0;
      stop_n <= 1;
      go(LDC_OPERATIONAL);
   endtask : t_warm
   task t_lanes;
      @(posedge clk);
      lanes <= 16'h00ff;
      in_st <= INLANE_SCRAMBLE;
      stop_n <= 0;
      go(LDC_DISCONNECTED);
      repeat (3) @(posedge clk);
      #1;
      `CHK(inact, 16'hff00)
      @(posedge clk);
      stop_n <= 1;
      wlock <= 1;
      go(LDC_OPERATIONAL);
      repeat (4) @(posedge clk);
      #1;
      `CHK(scr, 16'hff00)
      `CHK(tmo, 1'b0)
      @(posedge clk);
      wlock <= 0;
      repeat (300) @(posedge clk);
      #1;
      `CHK(tmo, 1'b1)
      @(posedge clk);
      stop_n <= 0;
      go(LDC_DISCONNECTED);
      repeat (3) @(posedge clk);
      #1;
      `CHK(scr, 16'h0000)
      @(posedge clk);
      tx_off <= 1;
      go(LDC_PHY_OFF);
      @(posedge clk);
      lanes <= 16'hffff;
   endtask : t_lanes
   initial begin
      rst_b = 0;
      stop_n = 1;
      lrst_n = 0;
      tx_off = 0;
      freq = 0;
      slow = 0;
      sel = 0;
      in_st = 0;
      lanes = 16'hffff;
      lim = 24'h00ffff;
      wlock = 0;
      do_reset();
      for (int s = 0; s < 4; s++) t_sleep(s[1:0]);
      t_idle();
      t_retune();
      t_warm();
      t_lanes();
      do_reset();
      finish_test();
   end
   initial begin
      #400000;
      n_mismatch++;
      finish_test();
   end
endmodule : tb_ldc_disconnected_ctrl
